// [design/ddc_regs.sv]
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// register bank and control decode for two voltage-output converters
module ddc_regs #(
    parameter int ADDR_W = 8,
    parameter int CODE_W = 8
) (
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    input  wire logic              sleep_mode,
    output ddc_pkg::ddc_conv_t     conv1,
    output ddc_pkg::ddc_conv_t     conv2,
    output logic                   analog_out_pin_zero_en,
    output logic                   analog_out_pin_two_en
);

    if (ADDR_W < 8 || CODE_W != 8) begin : g_bad_param
        $error("ddc_regs: ADDR_W must be >= 8 and CODE_W must be 8");
    end

    ddc_pkg::ddc_state_t st_q;
    ddc_pkg::ddc_state_t st_d;
    logic                done_q;
    logic                req;
    logic                wr_lane;
    logic [7:0]          wdat;
    logic [7:0]          addr8;

    assign req     = avs_read | avs_write;
    assign addr8   = avs_address[7:0];
    // registers are byte-wide, so only lane 0 carries a write; it lands
    // at the edge where waitrequest is low, as the bus expects
    assign wr_lane = avs_write & avs_byteenable[0] & done_q;
    assign wdat    = avs_writedata[7:0];
    // one wait cycle per access: answer comes at the second edge
    assign avs_waitrequest = req & ~done_q;

    always_comb begin
        st_d = st_q;
        // read data captured in the wait cycle, so it stands when sampled
        if (req && !done_q) begin
            case (addr8)
                ddc_pkg::DDC_ADDR_DAC1_LEVEL: begin
                    st_d.rdata = st_q.level1;
                end
                ddc_pkg::DDC_ADDR_DAC1_CTRL: begin
                    st_d.rdata = st_q.ctrl1;
                end
                ddc_pkg::DDC_ADDR_DAC2_LEVEL: begin
                    st_d.rdata = st_q.level2;
                end
                ddc_pkg::DDC_ADDR_DAC2_CTRL: begin
                    st_d.rdata = st_q.ctrl2;
                end
                default: begin
                    st_d.rdata = 8'h00;
                end
            endcase
        end
        if (wr_lane) begin
            case (addr8)
                ddc_pkg::DDC_ADDR_DAC1_LEVEL: begin
                    st_d.level1 = wdat;
                end
                ddc_pkg::DDC_ADDR_DAC1_CTRL: begin
                    st_d.ctrl1 = wdat & ddc_pkg::DDC_CTRL1_MASK;
                end
                ddc_pkg::DDC_ADDR_DAC2_LEVEL: begin
                    st_d.level2 = wdat;
                end
                ddc_pkg::DDC_ADDR_DAC2_CTRL: begin
                    // no pin select on the second converter
                    st_d.ctrl2 = wdat & ddc_pkg::DDC_CTRL2_MASK;
                end
                default: begin
                end
            endcase
        end
    end

    // sleep is not a reset: contents ride through any wake-up
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_q.ctrl1  <= ddc_pkg::DDC_CTRL_RESET;
            st_q.ctrl2  <= ddc_pkg::DDC_CTRL_RESET;
            st_q.level1 <= ddc_pkg::DDC_LEVEL_RESET;
            st_q.level2 <= ddc_pkg::DDC_LEVEL_RESET;
            st_q.rdata  <= 8'h00;
            done_q      <= 1'b0;
        end else begin
            st_q   <= st_d;
            done_q <= req & ~done_q;
        end
    end

    assign avs_readdata = {24'h000000, st_q.rdata};

    function automatic ddc_pkg::ddc_conv_t decode(logic [7:0] c,
                                                  logic [7:0] lvl,
                                                  logic       slp);
        ddc_pkg::ddc_conv_t r;
        r.enable         = c[ddc_pkg::DDC_EN_BIT];
        r.pos_ref_select = ddc_pkg::ddc_pos_ref_t'(
                           c[ddc_pkg::DDC_POS_LSB +: 2]);
        r.neg_ref_select = c[ddc_pkg::DDC_NEG_BIT];
        // reference dropped in sleep to save current
        r.ref_on         = c[ddc_pkg::DDC_EN_BIT] & ~slp;
        r.level_code     = lvl;
        return r;
    endfunction

    assign conv1 = decode(st_q.ctrl1, st_q.level1, sleep_mode);
    assign conv2 = decode(st_q.ctrl2, st_q.level2, sleep_mode);

    // codes 00 and 11 leave both pins off, so at most one of the pair is high
    assign analog_out_pin_zero_en = st_q.ctrl1[ddc_pkg::DDC_EN_BIT] &
        (st_q.ctrl1[ddc_pkg::DDC_OUT_SEL_LSB +: 2]
         == ddc_pkg::DDC_OUT_PIN_ZERO);
    assign analog_out_pin_two_en = st_q.ctrl1[ddc_pkg::DDC_EN_BIT] &
        (st_q.ctrl1[ddc_pkg::DDC_OUT_SEL_LSB +: 2]
         == ddc_pkg::DDC_OUT_PIN_TWO);

endmodule

// [dv/ddc_regs_monitor.sv]
`timescale 1ns/1ps
module ddc_regs_monitor (
    input wire logic        ref_clk, sys_rst, sleep_mode,
    input wire logic        avs_read, avs_write, avs_waitrequest,
    input wire logic [31:0] avs_readdata,
    input ddc_pkg::ddc_conv_t conv1, conv2,
    input wire logic        analog_out_pin_zero_en, analog_out_pin_two_en
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    a_pin_onehot: assert property (
        !(analog_out_pin_zero_en && analog_out_pin_two_en)) else $error("two pins");
    a_ref_gate_one: assert property (
        conv1.ref_on == (conv1.enable && !sleep_mode)) else $error("ref1");
    a_ref_gate_two: assert property (
        conv2.ref_on == (conv2.enable && !sleep_mode)) else $error("ref2");
    a_pin_needs_en: assert property (
        analog_out_pin_zero_en || analog_out_pin_two_en |-> conv1.enable)
        else $error("pin while off");
    a_one_wait: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("wait");
    a_rd_upper_zero: assert property (
        avs_readdata[31:8] == 24'h0) else $error("upper");
    a_reset_clears: assert property (
        $past(sys_rst) |-> !conv1.enable && !conv2.enable &&
        !analog_out_pin_zero_en && conv1.level_code == 8'h0) else $error("rst");
    a_level_hold: assert property (
        !avs_write |=> $stable(conv1.level_code) && $stable(conv2.level_code))
        else $error("level moved");
endmodule
bind ddc_regs ddc_regs_monitor mon_u (.*);

// [dv/dual_dac_control_regs_tb.sv]
`timescale 1ns/1ps
`define CK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected %0t got %h exp %h", $time, g, e); end end
module dual_dac_control_regs_tb;
    logic ref_clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0;
    logic sleep_mode = 0, avs_waitrequest;
    logic analog_out_pin_zero_en, analog_out_pin_two_en;
    logic [7:0]  avs_address = 8'h00;
    logic [3:0]  avs_byteenable = 4'hf;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, r;
    ddc_pkg::ddc_conv_t conv1, conv2;
    int n_fail = 0, checks = 0, cyc = 0;
    ddc_regs dut_u (.*);
    initial forever #2.5 ref_clk = ~ref_clk;
    // a hung handshake must still reach the verdict
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin n_fail++; tally_and_finish(); end
    end
    task automatic acc(input logic w, input logic [7:0] a, d);
        avs_address <= a; avs_writedata <= {24'h0, d};
        avs_write <= w; avs_read <= !w;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
        r = avs_readdata; avs_read <= 0; avs_write <= 0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [7:0] a, e);
        acc(0, a, 8'h00); `CK(r, {24'h0, e})
    endtask
    task t_reset;
        rd(8'h7d, 8'h00); rd(8'ha0, 8'h00);
        rd(8'h7f, 8'h00); rd(8'ha2, 8'h00);
        `CK({analog_out_pin_zero_en, analog_out_pin_two_en}, 2'b00)
        $display("t_reset done");
    endtask
    task t_ctrl1;
        acc(1, 8'h7f, 8'hf7); rd(8'h7f, 8'hb5);
        for (int i = 0; i < 4; i++) begin
            acc(1, 8'h7f, {2'b10, i[1:0], 2'(i % 3), 1'b0, i[0]});
            `CK({analog_out_pin_zero_en, analog_out_pin_two_en}, {i == 1, i == 2})
            `CK(conv1.pos_ref_select, 2'(i % 3))
            `CK({conv1.enable, conv1.neg_ref_select}, {1'b1, i[0]})
        end
        acc(1, 8'h7f, 8'h10); `CK({conv1.enable, analog_out_pin_zero_en}, 2'b00)
        $display("t_ctrl1 done");
    endtask
    task t_ctrl2;
        acc(1, 8'ha2, 8'hf7); rd(8'ha2, 8'h85);
        `CK({analog_out_pin_zero_en, analog_out_pin_two_en, conv2.enable}, 3'b001)
        `CK(conv2.pos_ref_select, 2'h1)
        $display("t_ctrl2 done");
    endtask
    task t_level;
        logic [7:0] v[3] = '{8'ha5, 8'h5a, 8'hff};
        foreach (v[k]) begin
            acc(1, 8'h7d, v[k]); acc(1, 8'ha0, ~v[k]);
            rd(8'h7d, v[k]); rd(8'ha0, ~v[k]);
            `CK({conv1.level_code, conv2.level_code}, {v[k], ~v[k]})
        end
        acc(1, 8'h7e, 8'h11); rd(8'h7e, 8'h00); rd(8'h7d, 8'hff);
        avs_byteenable <= 4'he; acc(1, 8'h7d, 8'h00);
        avs_byteenable <= 4'hf; rd(8'h7d, 8'hff);
        $display("t_level done");
    endtask
    task t_sleep;
        acc(1, 8'h7f, 8'h84);
        sleep_mode <= 1; @(posedge ref_clk); @(posedge ref_clk);
        `CK({conv1.ref_on, conv2.ref_on}, 2'b00)
        sleep_mode <= 0; @(posedge ref_clk); @(posedge ref_clk);
        `CK({conv1.ref_on, conv2.ref_on}, 2'b11)
        rd(8'h7f, 8'h84); rd(8'h7d, 8'hff); rd(8'ha2, 8'h85);
        $display("t_sleep done");
    endtask
    task tally_and_finish;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge ref_clk);
        sys_rst <= 0; @(posedge ref_clk);
        t_reset; t_ctrl1; t_ctrl2; t_level; t_sleep;
        tally_and_finish();
    end
endmodule

// [inc/ddc_pkg.sv]
// Behaviour
// - each converter is enabled while control bit 7 is set.
// - first converter bits 5:4 pick pin zero (01), pin two (10), else none.
// - bits 3:2 pick supply, external positive, fixed buffer; 11 is reserved.
// - bit 0 picks external negative reference when set, ground when clear.
// - each converter has an 8-bit read/write level code register.
// - wake from sleep by interrupt or watchdog keeps register contents.
// - the converter reference is switched off while the device sleeps.
// - device reset clears the enable bit.
// - device reset disconnects the output from every pin.
// - device reset clears the level code to zero.
// - second converter has no pin select; output goes only internal.
// - at most one output pin enable is high at any time.
// - the ladder offers 2^n levels chosen by the n-bit level code.
package ddc_pkg;

    localparam logic [7:0] DDC_ADDR_DAC1_LEVEL = 8'h7d;
    localparam logic [7:0] DDC_ADDR_DAC1_CTRL  = 8'h7f;
    localparam logic [7:0] DDC_ADDR_DAC2_LEVEL = 8'ha0;
    localparam logic [7:0] DDC_ADDR_DAC2_CTRL  = 8'ha2;

    localparam int DDC_EN_BIT      = 7;
    localparam int DDC_OUT_SEL_LSB = 4;
    localparam int DDC_POS_LSB     = 2;
    localparam int DDC_NEG_BIT     = 0;

    localparam logic [7:0] DDC_CTRL1_MASK = 8'hbd;
    localparam logic [7:0] DDC_CTRL2_MASK = 8'h8d;
    localparam logic [7:0] DDC_CTRL_RESET  = 8'h00;
    localparam logic [7:0] DDC_LEVEL_RESET = 8'h00;

    localparam logic [1:0] DDC_OUT_PIN_ZERO = 2'h1;
    localparam logic [1:0] DDC_OUT_PIN_TWO  = 2'h2;

    typedef enum logic [1:0] {
        DDC_POS_SUPPLY = 2'h0,
        DDC_POS_EXT    = 2'h1,
        DDC_POS_FIXED  = 2'h2,
        DDC_POS_RSVD   = 2'h3
    } ddc_pos_ref_t;

    typedef struct packed {
        logic         enable;
        ddc_pos_ref_t pos_ref_select;
        logic         neg_ref_select;
        logic         ref_on;
        logic [7:0]   level_code;
    } ddc_conv_t;

    typedef struct packed {
        logic [7:0] ctrl1;
        logic [7:0] level1;
        logic [7:0] ctrl2;
        logic [7:0] level2;
        logic [7:0] rdata;
    } ddc_state_t;

endpackage
